// [baud_generator.v]
// Prescaler and 16-bit divisor producing the sampling tick and bit tick.
// Assumes all inputs are synchronous to ref_clk; ticks are one-cycle pulses, except sample_tick stays high at divisor 1 without prescale.
`default_nettype none
`include "uart_rdy_defines.vh"

module baud_generator (
	input wire ref_clk,
	input wire reset_n,
	input wire prescale_div4,
	input wire sample_rate_16,
	input wire [15:0] divisor,
	output reg sample_tick,
	output reg bit_tick
);

	reg [2:0] pre_cnt_r;
	reg [15:0] div_cnt_r;
	reg [4:0] smp_cnt_r;
	wire pre_tick;
	wire [2:0] pre_limit;
	wire [4:0] smp_limit;

	// ------------------------------------------------------------------
	// Prescaler: divide by 1 or 4
	// ------------------------------------------------------------------
	assign pre_limit = prescale_div4 ? `PRESCALE_SLOW : 3'd1;
	assign pre_tick = (pre_cnt_r == pre_limit - 3'd1);
	assign smp_limit = sample_rate_16 ? `SAMPLES_X16 : `SAMPLES_X8;

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_cnt_r <= 3'd0;
		end else if (pre_tick || pre_cnt_r >= pre_limit) begin
			pre_cnt_r <= 3'd0;
		end else begin
			pre_cnt_r <= pre_cnt_r + 3'd1;
		end
	end

	// ------------------------------------------------------------------
	// Divisor counter; divisor zero stops the clock
	// ------------------------------------------------------------------
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt_r <= 16'h0000;
			sample_tick <= 1'b0;
		end else begin
			sample_tick <= 1'b0;
			if (divisor == 16'h0000) begin
				div_cnt_r <= 16'h0000;
			end else if (pre_tick) begin
				if (div_cnt_r >= divisor - 16'h0001) begin
					div_cnt_r <= 16'h0000;
					sample_tick <= 1'b1;
				end else begin
					div_cnt_r <= div_cnt_r + 16'h0001;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Oversampling: 8 or 16 samples per bit
	// ------------------------------------------------------------------
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			smp_cnt_r <= 5'd0;
			bit_tick <= 1'b0;
		end else begin
			bit_tick <= 1'b0;
			if (sample_tick) begin
				if (smp_cnt_r >= smp_limit - 5'd1) begin
					smp_cnt_r <= 5'd0;
					bit_tick <= 1'b1;
				end else begin
					smp_cnt_r <= smp_cnt_r + 5'd1;
				end
			end
		end
	end

endmodule // baud_generator
`default_nettype wire

// [fifo_side_model.sv]
// Far-side model: the channel's FIFOs as seen from the ready/interrupt block.
// Assumes the bench sets target levels; it steps one byte per clock.
`default_nettype none
module fifo_side_model #(
	parameter DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [7:0] rx_target,
	input wire logic [7:0] tx_target,
	input wire logic tsr_hold,
	output logic [7:0] rx_level,
	output logic [7:0] tx_level,
	output logic rx_push,
	output logic rx_pop,
	output logic tsr_empty
);
	// One byte per clock, so every rx level step is seen as a push or pop
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_level <= 8'h00;
			tx_level <= 8'h00;
			rx_push <= 1'b0;
			rx_pop <= 1'b0;
			tsr_empty <= 1'b1;
		end else begin
			rx_push <= rx_target > rx_level;
			rx_pop <= rx_target < rx_level;
			if (rx_target > rx_level)
				rx_level <= rx_level + 8'h01;
			else if (rx_target < rx_level)
				rx_level <= rx_level - 8'h01;
			if (tx_target > tx_level && tx_level < 8'(DEPTH))
				tx_level <= tx_level + 8'h01;
			else if (tx_target < tx_level)
				tx_level <= tx_level - 8'h01;
			tsr_empty <= !tsr_hold && tx_level == 8'h00;
		end
	end
endmodule // fifo_side_model
`default_nettype wire

// [rx_timeout.v]
// Receive timeout: four word lengths plus twelve bit times of silence.
// Assumes bit_tick pulses once per bit time and activity marks any push or pop.
`default_nettype none
`include "uart_rdy_defines.vh"

module rx_timeout (
	input wire ref_clk,
	input wire reset_n,
	input wire bit_tick,
	input wire activity,
	input wire data_held,
	input wire [1:0] word_len,
	output reg timeout
);

	reg [7:0] bits_r;
	reg fired_r;
	wire [7:0] word_bits;
	wire [7:0] limit;

	assign word_bits = `WORD_BASE_BITS + {6'd0, word_len};
	assign limit = (word_bits << 2) + `TIMEOUT_EXTRA_BITS;

	// Fires once per quiet spell; only while data waits to be read
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			bits_r <= 8'd0;
			fired_r <= 1'b0;
			timeout <= 1'b0;
		end else begin
			timeout <= 1'b0;
			if (activity || !data_held) begin
				bits_r <= 8'd0;
				fired_r <= 1'b0;
			end else if (bit_tick && !fired_r) begin
				if (bits_r >= limit - 8'd1) begin
					timeout <= 1'b1;
					fired_r <= 1'b1;
				end else begin
					bits_r <= bits_r + 8'd1;
				end
			end
		end
	end

endmodule // rx_timeout
`default_nettype wire

// [uart_rdy_defines.vh]
// Constants for the ready/interrupt pins and baud path of one UART channel.
// Assumes inclusion by bare name from the design files of this folder.
`ifndef UART_RDY_DEFINES_VH
`define UART_RDY_DEFINES_VH

// ----------------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define REG_FIFO_CTRL 4'h0
`define REG_LINE_CTRL 4'h1
`define REG_MODEM_CTRL 4'h2
`define REG_FEAT_CTRL 4'h3
`define REG_DIV_LOW 4'h4
`define REG_DIV_HIGH 4'h5
`define REG_RX_TRIG 4'h6
`define REG_TX_TRIG 4'h7
`define REG_PIN_STATE 4'h8
`define REG_IRQ_STATUS 4'h9
`define REG_IRQ_MASK 4'hA

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FCR_FIFO_EN 0
`define FCR_BLOCK 3
`define MCR_PRESCALE 7
`define FEAT_HALF_DUPLEX 3
`define LCR_WLEN_HI 1
`define LCR_WLEN_LO 0
`define EVT_RX_TRIG 0
`define EVT_RX_TIMEOUT 1
`define EVT_TX_LOW 2
`define EVT_TX_FULL 3
`define EVT_WIDTH 4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_RX_TRIG 8'h01
`define RST_TX_TRIG 8'h01
`define RST_EVT 4'h0
`define RST_EVT_IDLE 4'h4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define RESET_MIN_NS 40
`define RESET_MIN_CYCLES ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRESCALE_SLOW 3'd4
`define SAMPLES_X8 5'd8
`define SAMPLES_X16 5'd16
`define WORD_BASE_BITS 8'd5
`define TIMEOUT_WORDS 4
`define TIMEOUT_EXTRA_BITS 8'd12

`endif

// [uart_ready_irq.v]
// One UART channel: ready pins, interrupt pin, baud path, Avalon-MM registers.
// Assumes FIFO levels and strobes come from the channel's FIFOs on ref_clk;
// a second channel is a second instance with its own registers and pins.
//
// Summary of operation
// - Single-char mode: rx ready low while data held
// - Block mode: rx ready falls at trigger/timeout
// - Single-char mode: tx room low while empty
// - Block mode: tx room high only when full
// - FIFO control bit 0 enables, bit 3 blocks
// - Tx interrupt level follows FIFO trigger comparison; tx empty with FIFOs off
// - Half-duplex: interrupt high when transmitter empties
// - Rx interrupt level high at or above trigger level; while data held with FIFOs off
// - Register access independent of baud path
// - Prescale 1 or 4, register overrides pin
// - Divisor 1 to 65535 divides prescaler output
// - Divisor built from high and low bytes
// - Sample-rate pin picks 8x or 16x
// - One sampling clock for transmit and receive
// - Reset clears registers but triggers (1); waitrequest, rx ready high
// - Half-duplex off after reset, feature bit 3
// - Timeout after four words plus twelve bits
`default_nettype none
`include "uart_rdy_defines.vh"

module uart_ready_irq #(
	parameter FIFO_DEPTH = 128,
	parameter LEVEL_W = 8
) (
	input wire ref_clk,
	input wire reset_n,
	input wire [3:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	output reg [31:0] readdata,
	output reg waitrequest,
	output reg irq,
	input wire prescale_select_pin,
	input wire sample_rate_select_pin,
	input wire [LEVEL_W-1:0] rx_level,
	input wire [LEVEL_W-1:0] tx_level,
	input wire tsr_empty,
	input wire rx_push,
	input wire rx_pop,
	output reg rx_ready_n,
	output reg tx_room_n,
	output reg irq_out_first,
	output wire sample_tick,
	output wire bit_tick
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function reached;
		input [LEVEL_W-1:0] level;
		input [LEVEL_W-1:0] trig;
		begin
			reached = (level != {LEVEL_W{1'b0}}) && (level >= trig);
		end
	endfunction

	// Strictly above: a level equal to the trigger is not above it
	function above;
		input [LEVEL_W-1:0] level;
		input [LEVEL_W-1:0] trig;
		begin
			above = (level > trig);
		end
	endfunction

	function [31:0] byte_word;
		input [7:0] value;
		begin
			byte_word = {24'h00_0000, value};
		end
	endfunction

	localparam [LEVEL_W-1:0] FULL_LEVEL = FIFO_DEPTH[LEVEL_W-1:0];
	localparam [LEVEL_W-1:0] ZERO_LEVEL = {LEVEL_W{1'b0}};

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	reg [7:0] fifo_control_reg;
	reg [7:0] line_control_reg;
	reg [7:0] modem_control_reg;
	reg [7:0] feature_control_reg;
	reg [7:0] divisor_low_byte;
	reg [7:0] divisor_high_byte;
	reg [7:0] rx_trig_r;
	reg [7:0] tx_trig_r;
	reg [`EVT_WIDTH-1:0] evt_status_r;
	reg [`EVT_WIDTH-1:0] evt_mask_r;
	reg prescale_override_r;
	reg block_rx_low_r;
	reg [`EVT_WIDTH-1:0] evt_level_prev_r;

	wire fifo_on;
	wire block_mode;
	wire half_duplex;
	wire prescale_div4;
	wire [15:0] divisor;
	wire rx_timeout_pulse;
	wire rx_held;
	wire tx_empty;
	wire tx_full;
	wire rx_at_trig;
	wire tx_above_trig;
	wire wr_en;
	wire [`EVT_WIDTH-1:0] evt_level;
	wire [7:0] pin_state;
	reg [`EVT_WIDTH-1:0] evt_rise;
	reg rx_ready_n_nxt;
	reg tx_room_n_nxt;
	reg irq_tx_high;
	reg irq_rx_high;
	reg [31:0] readdata_nxt;

	assign fifo_on = fifo_control_reg[`FCR_FIFO_EN];
	assign block_mode = fifo_on && fifo_control_reg[`FCR_BLOCK];
	assign half_duplex = feature_control_reg[`FEAT_HALF_DUPLEX];
	assign divisor = {divisor_high_byte, divisor_low_byte};
	// Pin rules until software writes the modem control register
	assign prescale_div4 = prescale_override_r ?
		modem_control_reg[`MCR_PRESCALE] : prescale_select_pin;

	assign rx_held = (rx_level != ZERO_LEVEL);
	assign tx_empty = (tx_level == ZERO_LEVEL);
	// A level past the depth still counts as full
	assign tx_full = (tx_level >= FULL_LEVEL);
	assign rx_at_trig = reached(rx_level, rx_trig_r);
	assign tx_above_trig = above(tx_level, tx_trig_r);
	assign pin_state = {3'b000, prescale_div4, block_rx_low_r,
		irq_out_first, tx_room_n, rx_ready_n};

	// ------------------------------------------------------------------
	// Baud path and receive timeout
	// ------------------------------------------------------------------
	baud_generator u_baud (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.prescale_div4(prescale_div4),
		.sample_rate_16(sample_rate_select_pin),
		.divisor(divisor),
		.sample_tick(sample_tick),
		.bit_tick(bit_tick)
	);

	rx_timeout u_rx_timeout (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.bit_tick(bit_tick),
		.activity(rx_push | rx_pop),
		.data_held(rx_held),
		.word_len(line_control_reg[`LCR_WLEN_HI:`LCR_WLEN_LO]),
		.timeout(rx_timeout_pulse)
	);

	// ------------------------------------------------------------------
	// Bus slave: one wait state, then the answer
	// ------------------------------------------------------------------
	// The bus runs on ref_clk only; no baud tick gates an access.
	assign wr_en = write && !waitrequest;

	// Fixed single wait state, so every register answers alike
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			waitrequest <= 1'b1;
		end else if ((read || write) && waitrequest) begin
			waitrequest <= 1'b0;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	always @* begin
		readdata_nxt = 32'h0000_0000;
		case (address)
		`REG_FIFO_CTRL: readdata_nxt = byte_word(fifo_control_reg);
		`REG_LINE_CTRL: readdata_nxt = byte_word(line_control_reg);
		`REG_MODEM_CTRL: readdata_nxt = byte_word(modem_control_reg);
		`REG_FEAT_CTRL: readdata_nxt = byte_word(feature_control_reg);
		`REG_DIV_LOW: readdata_nxt = byte_word(divisor_low_byte);
		`REG_DIV_HIGH: readdata_nxt = byte_word(divisor_high_byte);
		`REG_RX_TRIG: readdata_nxt = byte_word(rx_trig_r);
		`REG_TX_TRIG: readdata_nxt = byte_word(tx_trig_r);
		`REG_PIN_STATE: readdata_nxt = byte_word(pin_state);
		`REG_IRQ_STATUS: readdata_nxt = {28'h000_0000, evt_status_r};
		`REG_IRQ_MASK: readdata_nxt = {28'h000_0000, evt_mask_r};
		default: readdata_nxt = 32'h0000_0000;
		endcase
	end

	// Taken at the edge that drops waitrequest and held until the next read
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			readdata <= 32'h0000_0000;
		end else if (read && waitrequest) begin
			readdata <= readdata_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Control register writes
	// ------------------------------------------------------------------
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			fifo_control_reg <= `RST_BYTE;
			line_control_reg <= `RST_BYTE;
			modem_control_reg <= `RST_BYTE;
			feature_control_reg <= `RST_BYTE;
			divisor_low_byte <= `RST_BYTE;
			divisor_high_byte <= `RST_BYTE;
			rx_trig_r <= `RST_RX_TRIG;
			tx_trig_r <= `RST_TX_TRIG;
			evt_mask_r <= `RST_EVT;
			prescale_override_r <= 1'b0;
		end else if (wr_en) begin
			case (address)
			`REG_FIFO_CTRL: fifo_control_reg <= writedata[7:0];
			`REG_LINE_CTRL: line_control_reg <= writedata[7:0];
			`REG_MODEM_CTRL: begin
				modem_control_reg <= writedata[7:0];
				prescale_override_r <= 1'b1;
			end
			`REG_FEAT_CTRL: feature_control_reg <= writedata[7:0];
			`REG_DIV_LOW: divisor_low_byte <= writedata[7:0];
			`REG_DIV_HIGH: divisor_high_byte <= writedata[7:0];
			`REG_RX_TRIG: rx_trig_r <= writedata[7:0];
			`REG_TX_TRIG: tx_trig_r <= writedata[7:0];
			`REG_IRQ_MASK: evt_mask_r <= writedata[`EVT_WIDTH-1:0];
			default: evt_mask_r <= evt_mask_r;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Ready pins
	// ------------------------------------------------------------------
	// Block-mode receive latch: low from trigger/timeout until empty
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			block_rx_low_r <= 1'b0;
		end else if (!rx_held) begin
			block_rx_low_r <= 1'b0;
		end else if (rx_at_trig || rx_timeout_pulse) begin
			block_rx_low_r <= 1'b1;
		end
	end

	// Block mode: the receive pin stays low until the FIFO drains
	always @* begin
		if (block_mode) begin
			rx_ready_n_nxt = !(block_rx_low_r || rx_at_trig ||
				rx_timeout_pulse) || !rx_held;
			tx_room_n_nxt = tx_full;
		end else begin
			rx_ready_n_nxt = !rx_held;
			tx_room_n_nxt = !tx_empty;
		end
	end

	// ------------------------------------------------------------------
	// Interrupt pin level
	// ------------------------------------------------------------------
	// Transmit and receive parts are ORed onto the one pin
	always @* begin
		if (half_duplex) begin
			if (fifo_on) begin
				irq_tx_high = !tx_above_trig ||
					(tx_empty && tsr_empty);
			end else begin
				irq_tx_high = tx_empty && tsr_empty;
			end
		end else if (fifo_on) begin
			irq_tx_high = !tx_above_trig;
		end else begin
			irq_tx_high = tx_empty;
		end
		if (fifo_on) begin
			irq_rx_high = rx_at_trig;
		end else begin
			irq_rx_high = rx_held;
		end
	end

	// Registered, so a mode change never glitches a pin
	// Each instance owns its pins; nothing is shared between channels
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_ready_n <= 1'b1;
			tx_room_n <= 1'b0;
			irq_out_first <= 1'b0;
		end else begin
			rx_ready_n <= rx_ready_n_nxt;
			tx_room_n <= tx_room_n_nxt;
			irq_out_first <= irq_tx_high || irq_rx_high;
		end
	end

	// ------------------------------------------------------------------
	// Sticky events, mask, interrupt line
	// ------------------------------------------------------------------
	assign evt_level[`EVT_RX_TRIG] = rx_at_trig;
	assign evt_level[`EVT_RX_TIMEOUT] = 1'b0;
	assign evt_level[`EVT_TX_LOW] = !tx_above_trig;
	assign evt_level[`EVT_TX_FULL] = tx_full;

	// The timeout is a pulse already and needs no edge detector
	always @* begin
		evt_rise = evt_level & ~evt_level_prev_r;
		evt_rise[`EVT_RX_TIMEOUT] = rx_timeout_pulse;
	end

	// A new event in the clearing cycle survives: set beats clear
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			evt_status_r <= `RST_EVT;
			evt_level_prev_r <= `RST_EVT_IDLE; // No edge out of reset
			irq <= 1'b0;
		end else begin
			evt_level_prev_r <= evt_level;
			if (wr_en && address == `REG_IRQ_STATUS) begin
				evt_status_r <= (evt_status_r &
					~writedata[`EVT_WIDTH-1:0]) | evt_rise;
			end else begin
				evt_status_r <= evt_status_r | evt_rise;
			end
			irq <= |(evt_status_r & evt_mask_r);
		end
	end

endmodule // uart_ready_irq
`default_nettype wire

// [uart_ready_irq_chk.sv]
// Assertions on the ready, interrupt, bus and sample tick pins of one channel.
// Assumes a bind to uart_ready_irq; control registers mirrored from writes.
`default_nettype none
`include "uart_rdy_defines.vh"
module uart_ready_irq_chk #(
	parameter FIFO_DEPTH = 128,
	parameter LEVEL_W = 8
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic waitrequest,
	input wire logic irq,
	input wire logic [LEVEL_W-1:0] rx_level,
	input wire logic [LEVEL_W-1:0] tx_level,
	input wire logic rx_ready_n,
	input wire logic tx_room_n,
	input wire logic sample_tick
);
	logic [7:0] fcr_r;
	logic [7:0] trig_r;
	logic [3:0] mask_r;
	logic [15:0] div_r;
	wire blk = fcr_r[`FCR_FIFO_EN] & fcr_r[`FCR_BLOCK];
	// ----------------------------------------------------------------
	// Register mirror, updated at the edge that accepts a write
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			fcr_r <= 8'h00;
			trig_r <= 8'h01;
			mask_r <= 4'h0;
			div_r <= 16'h0000;
		end else if (write && !waitrequest) begin
			case (address)
			`REG_FIFO_CTRL: fcr_r <= writedata[7:0];
			`REG_RX_TRIG: trig_r <= writedata[7:0];
			`REG_IRQ_MASK: mask_r <= writedata[3:0];
			`REG_DIV_LOW: div_r[7:0] <= writedata[7:0];
			`REG_DIV_HIGH: div_r[15:8] <= writedata[7:0];
			default: ;
			endcase
		end
	end
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence s_rx_hit;
		blk && rx_level >= trig_r && rx_level != 0;
	endsequence
	sequence s_div_zero;
		div_r == 16'h0000 [*5];
	endsequence
	chk_wait_one: assert property (
		$fell(waitrequest) |=> waitrequest) else $error("wait low too long");
	chk_req_answer: assert property (
		(read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered");
	chk_rx_single: assert property (
		!blk |=> rx_ready_n == ($past(rx_level) == 0))
		else $error("rx ready wrong");
	chk_tx_single: assert property (
		!blk |=> tx_room_n == ($past(tx_level) != 0))
		else $error("tx room wrong");
	chk_tx_block: assert property (
		blk |=> tx_room_n == ($past(tx_level) == FIFO_DEPTH))
		else $error("tx room wrong in block mode");
	chk_rx_trig_hit: assert property (
		s_rx_hit |=> !rx_ready_n) else $error("rx ready missed trigger");
	chk_rx_block_rise: assert property (
		$rose(rx_ready_n) && $past(blk) |-> $past(rx_level) == 0)
		else $error("rx ready rose while data held");
	chk_irq_masked: assert property (
		mask_r == 4'h0 && $past(mask_r) == 4'h0 |-> !irq)
		else $error("irq while all masked");
	chk_tick_stop: assert property (
		s_div_zero |=> !sample_tick) else $error("tick with divisor zero");
endmodule // uart_ready_irq_chk
`default_nettype wire

// [uart_ready_irq_tb.sv]
// Bench for one channel: bus tasks, far-side FIFO model, pin and tick checks.
// Assumes the design, its defines header, the model and the checker.
`default_nettype none
`include "uart_rdy_defines.vh"
module uart_ready_irq_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam DEPTH = 8;
	typedef struct packed {logic [3:0] a; logic [31:0] m; logic [31:0] e;} note_t;
	logic ref_clk, reset_n, read, write, tsr_hold, rx_push, rx_pop, tsr_empty;
	logic prescale_select_pin, sample_rate_select_pin, sample_tick, bit_tick;
	logic waitrequest, irq, rx_ready_n, tx_room_n, irq_out_first;
	logic [3:0] address;
	logic [31:0] writedata, readdata;
	logic [7:0] rx_level, tx_level, rx_t, tx_t;
	logic [7:0] fcrs [3] = '{8'h00, 8'h01, 8'h08};
	note_t notes[$];
	note_t nt;
	int mismatches, n_compared, seed, i, t, n;
	uart_ready_irq #(.FIFO_DEPTH(DEPTH), .LEVEL_W(8)) u_dut (
		.ref_clk(ref_clk), .reset_n(reset_n), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .irq(irq),
		.prescale_select_pin(prescale_select_pin),
		.sample_rate_select_pin(sample_rate_select_pin),
		.rx_level(rx_level), .tx_level(tx_level), .tsr_empty(tsr_empty),
		.rx_push(rx_push), .rx_pop(rx_pop), .rx_ready_n(rx_ready_n),
		.tx_room_n(tx_room_n), .irq_out_first(irq_out_first),
		.sample_tick(sample_tick), .bit_tick(bit_tick));
	fifo_side_model #(.DEPTH(DEPTH)) u_far (.ref_clk(ref_clk),
		.reset_n(reset_n), .rx_target(rx_t), .tx_target(tx_t),
		.tsr_hold(tsr_hold), .rx_level(rx_level), .tx_level(tx_level),
		.rx_push(rx_push), .rx_pop(rx_pop), .tsr_empty(tsr_empty));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task check(input string what, input logic [31:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task final_report;
		$display("compared %0d mismatched %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task wait_ack;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		if (n >= 50)
			check("bus answer", 32'h0000_0001, 32'h0000_0000);
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		address <= a;
		writedata <= d;
		write <= 1'b1;
		wait_ack;
		write <= 1'b0;
	endtask
	// The note is queued before the request; the monitor takes it back
	task rd(input logic [3:0] a, input logic [31:0] e, m);
		notes.push_back('{a, m, e});
		@(posedge ref_clk);
		address <= a;
		read <= 1'b1;
		wait_ack;
		read <= 1'b0;
	endtask
	task set_lv(input logic [7:0] r, x);
		@(posedge ref_clk);
		rx_t <= r;
		tx_t <= x;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while ((rx_level !== r || tx_level !== x) && n < 40);
		repeat (2) @(posedge ref_clk);
	endtask
	// First interval is skipped: a new divisor may cut it short
	task gap(input string what, input int exp);
		repeat (2) begin
			n = 0;
			do begin
				@(posedge ref_clk);
				n++;
			end while (sample_tick !== 1'b1 && n < 3000);
		end
		check(what, exp, n);
	endtask
	task ratio(input int exp);
		int k;
		repeat (2) begin
			n = 0;
			k = 0;
			do begin
				@(posedge ref_clk);
				n += (sample_tick === 1'b1);
				k++;
			end while (bit_tick !== 1'b1 && k < 3000);
		end
		check("ticks per bit", exp, n);
	endtask
	task tmo(input logic [1:0] wl, input int bits);
		wr(`REG_LINE_CTRL, {30'h0, wl});
		set_lv(8'h00, 8'h00);
		rx_t <= 8'h01;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (rx_ready_n !== 1'b0 && n < 2000);
		check("timeout span", 1, n > bits * 8 - 16 && n < bits * 8 + 24);
	endtask
	always @(posedge ref_clk) begin
		if (read === 1'b1 && waitrequest === 1'b0 && notes.size() > 0) begin
			nt = notes.pop_front();
			check($sformatf("reg %h", nt.a), nt.e, readdata & nt.m);
		end
	end
	initial begin
		repeat (60000) @(posedge ref_clk);
		mismatches++;
		final_report;
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{reset_n, read, write, tsr_hold, prescale_select_pin} = 5'b00000;
		{address, writedata, rx_t, tx_t} = 52'h0;
		{sample_rate_select_pin, seed, mismatches, n_compared} = {1'b1, 32'd78, 64'h0};
		repeat (5) @(posedge ref_clk);
		check("reset pins", 32'h0000_0018, {waitrequest, rx_ready_n, tx_room_n,
			irq_out_first, irq});
		reset_n <= 1'b1;
		wr(4'hB, 32'h0000_00FF);
		for (i = 0; i < 12; i++)
			rd(i[3:0], (i == 6 || i == 7) ? 1 : (i == 8 ? 5 : 0),
				32'h0000_00FF);
		for (i = 0; i < 3; i++) begin
			wr(`REG_FIFO_CTRL, {24'h0, fcrs[i]});
			set_lv(8'h00, 8'h00);
			check("empty", 32'h2, {rx_ready_n, tx_room_n});
			set_lv(8'h01, 8'h01);
			check("one byte", 32'h1, {rx_ready_n, tx_room_n});
		end
		wr(`REG_FIFO_CTRL, 32'h0000_0009);
		set_lv(8'h00, 8'h00);
		t = 2 + {$random(seed)} % 5;
		wr(`REG_RX_TRIG, t);
		set_lv(8'(t - 1), 8'(DEPTH - 1));
		check("below trigger", 32'h2, {rx_ready_n, tx_room_n});
		set_lv(8'(t), 8'(DEPTH));
		check("at trigger", 32'h1, {rx_ready_n, tx_room_n});
		set_lv(8'h01, 8'(DEPTH - 1));
		check("draining", 32'h0, {rx_ready_n, tx_room_n});
		set_lv(8'h00, 8'h00);
		check("drained", 32'h2, {rx_ready_n, tx_room_n});
		wr(`REG_FIFO_CTRL, 32'h0000_0000);
		tsr_hold <= 1'b1;
		set_lv(8'h00, 8'h00);
		check("tx idle", 1, irq_out_first);
		wr(`REG_FEAT_CTRL, 32'h0000_0008);
		set_lv(8'h00, 8'h00);
		check("shifting", 0, irq_out_first);
		tsr_hold <= 1'b0;
		set_lv(8'h00, 8'h00);
		check("tx empty", 1, irq_out_first);
		tsr_hold <= 1'b1;
		set_lv(8'h00, 8'h01);
		check("byte waits", 0, irq_out_first);
		wr(`REG_FEAT_CTRL, 32'h0000_0000);
		tsr_hold <= 1'b0;
		wr(`REG_FIFO_CTRL, 32'h0000_0001);
		wr(`REG_RX_TRIG, 32'h0000_0002);
		wr(`REG_TX_TRIG, 32'h0000_0002);
		set_lv(8'h00, 8'h03);
		check("tx above", 0, irq_out_first);
		set_lv(8'h03, 8'h03);
		check("rx above", 1, irq_out_first);
		set_lv(8'h00, 8'h01);
		check("tx below", 1, irq_out_first);
		wr(`REG_FEAT_CTRL, 32'h0000_0008);
		set_lv(8'h00, 8'h03);
		check("half duplex above", 0, irq_out_first);
		wr(`REG_FEAT_CTRL, 32'h0000_0000);
		wr(`REG_RX_TRIG, 32'h0000_0001);
		set_lv(8'h00, 8'h00);
		wr(`REG_IRQ_STATUS, 32'h0000_000F);
		wr(`REG_IRQ_MASK, 32'h0000_0001);
		check("irq idle", 0, irq);
		set_lv(8'h01, 8'h00);
		check("irq raised", 1, irq);
		rd(`REG_IRQ_STATUS, 32'h1, 32'h1);
		wr(`REG_IRQ_STATUS, 32'h0000_0001);
		repeat (2) @(posedge ref_clk);
		check("irq cleared", 0, irq);
		wr(`REG_IRQ_MASK, 32'h0000_0000);
		set_lv(8'h00, 8'h00);
		set_lv(8'h01, 8'h00);
		check("irq masked", 0, irq);
		rd(`REG_IRQ_STATUS, 32'h1, 32'h1);
		wr(`REG_DIV_LOW, 32'h0000_0003);
		gap("divide 3", 3);
		prescale_select_pin <= 1'b1;
		gap("pin by 4", 12);
		wr(`REG_MODEM_CTRL, 32'h0000_0000);
		gap("reg by 1", 3);
		wr(`REG_MODEM_CTRL, 32'h0000_0080);
		gap("reg by 4", 12);
		wr(`REG_MODEM_CTRL, 32'h0000_0000);
		wr(`REG_DIV_HIGH, 32'h0000_0001);
		wr(`REG_DIV_LOW, 32'h0000_0000);
		gap("divide 256", 256);
		wr(`REG_DIV_HIGH, 32'h0000_0000);
		wr(`REG_DIV_LOW, 32'h0000_0001);
		ratio(16);
		sample_rate_select_pin <= 1'b0;
		ratio(8);
		wr(`REG_FIFO_CTRL, 32'h0000_0009);
		wr(`REG_RX_TRIG, 32'h0000_0006);
		tmo(2'd0, 32);
		tmo(2'd3, 44);
		final_report;
	end
endmodule // uart_ready_irq_tb
bind uart_ready_irq uart_ready_irq_chk #(.FIFO_DEPTH(FIFO_DEPTH),
	.LEVEL_W(LEVEL_W)) u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
	.address(address), .read(read), .write(write), .writedata(writedata),
	.waitrequest(waitrequest), .irq(irq), .rx_level(rx_level),
	.tx_level(tx_level), .rx_ready_n(rx_ready_n), .tx_room_n(tx_room_n),
	.sample_tick(sample_tick));
`default_nettype wire
